// ===== hdl/xcvr_ctrl.sv
// Purpose: Control and status logic of a four-lane optical transceiver.
// Assumes: Pins arrive asynchronously; software uses Avalon-MM slave port.
// Notes:   Every response here is far faster than its documented bound,
//          except initialization and the reset pin filter, which run their full counts.
// Notes on behaviour
// - Fully functional within 2000 ms after power-on.
// - Low-power pin enters power level 1 fast.
// - Interrupt output falls within 200 ms.
// - Flags clear on read; interrupt releases promptly.
// - Reset pin counts only after 2 us low.
// - Functional within 2000 ms of reset pin rise.
// - Serial bus answers within 2000 ms of power-on.
// - Data-not-ready clears, interrupt raised after init.
// - Receive loss sets flag and interrupt.
// - Transmit fault sets flag and interrupt.
// - Other conditions set flag and interrupt.
// - Setting mask stops that flag's interrupt.
// - Clearing mask restores that flag's interrupt.
// - Power-down bit enters power level 1.
// - Clearing power-down restores full operation.
// - Receive signal loss squelches receive output.
// - Receive signal return restores receive output.
// - Transmit input loss squelches transmit output.
// - Transmit input return restores transmit output.
// - Transmit disable bit turns lane output off.
// - Clearing transmit disable restores lane output.
// - Receive disable bit turns receive output off.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
module xcvr_ctrl #(
   parameter int INIT_CYCLES = xcvr_ctrl_pkg::INIT_CYCLES
) (
   input  wire logic                             clk_in,
   input  wire logic                             rst_n_in,
   input  wire logic [xcvr_ctrl_pkg::ADDR_W-1:0] address_in,
   input  wire logic                             read_in,
   input  wire logic                             write_in,
   input  wire logic [31:0]                      writedata_in,
   input  wire logic [3:0]                       byteenable_in,
   output logic      [31:0]                      readdata_out,
   output logic                                  waitrequest_out,
   input  wire logic                             module_rst_n_in,
   input  wire logic                             low_power_pin_in,
   input  wire logic [xcvr_ctrl_pkg::LANES-1:0]  rx_los_in,
   input  wire logic [xcvr_ctrl_pkg::LANES-1:0]  tx_fault_in,
   input  wire logic [xcvr_ctrl_pkg::LANES-1:0]  tx_los_in,
   output logic                                  module_irq_n_out,
   output logic                                  ready_out,
   output logic                                  low_power_out,
   output logic      [xcvr_ctrl_pkg::LANES-1:0]  rx_squelch_out,
   output logic      [xcvr_ctrl_pkg::LANES-1:0]  tx_squelch_out,
   output logic      [xcvr_ctrl_pkg::LANES-1:0]  tx_off_out,
   output logic      [xcvr_ctrl_pkg::LANES-1:0]  rx_off_out
);
   localparam int L = xcvr_ctrl_pkg::LANES;

   xcvr_ctrl_pkg::pins_t       pins_raw;
   xcvr_ctrl_pkg::pins_t       sync_a;
   xcvr_ctrl_pkg::pins_t       sync_b;
   xcvr_ctrl_pkg::pins_t       pins_prev;
   xcvr_ctrl_pkg::init_state_t init_state;
   logic [31:0]                init_cnt;
   logic [8:0]                 rst_low_cnt;
   logic                       pin_reset;
   logic [12:0]                flags;
   logic [12:0]                mask;
   logic [11:0]                control;
   logic [12:0]                flag_set;
   logic [12:0]                flag_clr;
   logic                       ack;
   logic                       take_rd;
   logic                       take_wr;
   logic [31:0]                be_mask;
   logic [31:0]                status_word;
   logic                       not_ready;
   logic                       not_ready_prev;
   logic                       pending;

   assign pins_raw = '{rx_los: rx_los_in, tx_fault: tx_fault_in,
                       tx_los: tx_los_in, rst_n: module_rst_n_in,
                       low_power: low_power_pin_in};

   // Two-stage synchronizer; only sync_b and later stages feed logic.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // The reset pin idles high, so its stages start high as well.
         sync_a <= '{default: '0, rst_n: 1'b1};
         sync_b <= '{default: '0, rst_n: 1'b1};
         pins_prev <= '{default: '0, rst_n: 1'b1};
      end else begin
         sync_a <= pins_raw;
         sync_b <= sync_a;
         pins_prev <= sync_b;
      end
   end

   // A short glitch on the reset pin is ignored; only a long low level
   // holds the block in reset.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_low_cnt <= '0;
         pin_reset <= 1'b0;
      end else if (sync_b.rst_n) begin
         rst_low_cnt <= '0;
         pin_reset <= 1'b0;
      end else if (rst_low_cnt ==
                   9'(xcvr_ctrl_pkg::RST_MIN_CYCLES - 1)) begin
         pin_reset <= 1'b1;
      end else begin
         rst_low_cnt <= rst_low_cnt + 9'h001;
      end
   end

   // Initialization runs its full count after either reset is released.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         init_state <= xcvr_ctrl_pkg::INIT_WAIT;
         init_cnt <= '0;
      end else if (pin_reset) begin
         init_state <= xcvr_ctrl_pkg::PIN_RESET;
         init_cnt <= '0;
      end else begin
         unique case (init_state)
            xcvr_ctrl_pkg::PIN_RESET: begin
               init_state <= xcvr_ctrl_pkg::INIT_WAIT;
            end
            xcvr_ctrl_pkg::INIT_WAIT: begin
               if (init_cnt == 32'(INIT_CYCLES - 1)) begin
                  init_state <= xcvr_ctrl_pkg::RUNNING;
               end else begin
                  init_cnt <= init_cnt + 32'h0000_0001;
               end
            end
            xcvr_ctrl_pkg::RUNNING: begin
               init_state <= xcvr_ctrl_pkg::RUNNING;
            end
         endcase
      end
   end

   assign not_ready = (init_state != xcvr_ctrl_pkg::RUNNING);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         not_ready_prev <= 1'b1;
      end else begin
         not_ready_prev <= not_ready;
      end
   end

   // Avalon slave: one wait state on every access, also while the reset pin
   // holds the block, so the answer time is fixed.
   assign waitrequest_out = (read_in | write_in) & ~ack;
   assign take_rd = read_in & ack;
   assign take_wr = write_in & ack;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack <= 1'b0;
      end else begin
         ack <= (read_in | write_in) & ~ack;
      end
   end

   always_comb begin
      be_mask = '0;
      for (int b = 0; b < 4; b++) begin
         be_mask[8*b +: 8] = {8{byteenable_in[b]}};
      end
   end

   always_comb begin
      status_word = '0;
      status_word[xcvr_ctrl_pkg::ST_NOT_READY] = not_ready;
      status_word[xcvr_ctrl_pkg::ST_READY] = ~not_ready;
      status_word[xcvr_ctrl_pkg::ST_LOW_POWER] = low_power_out;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         readdata_out <= '0;
      end else if (read_in & ~ack) begin
         unique case (address_in)
            xcvr_ctrl_pkg::OFS_STATUS:  readdata_out <= status_word;
            xcvr_ctrl_pkg::OFS_FLAGS:   readdata_out <= 32'(flags);
            xcvr_ctrl_pkg::OFS_MASK:    readdata_out <= 32'(mask);
            xcvr_ctrl_pkg::OFS_CONTROL: readdata_out <= 32'(control);
            default:                    readdata_out <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask <= xcvr_ctrl_pkg::MASK_RESET;
      end else if (pin_reset) begin
         mask <= xcvr_ctrl_pkg::MASK_RESET;
      end else if (take_wr && address_in == xcvr_ctrl_pkg::OFS_MASK) begin
         mask <= (mask & ~be_mask[12:0]) | (writedata_in[12:0] & be_mask[12:0]);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         control <= xcvr_ctrl_pkg::CONTROL_RESET;
      end else if (pin_reset) begin
         control <= xcvr_ctrl_pkg::CONTROL_RESET;
      end else if (take_wr &&
                   address_in == xcvr_ctrl_pkg::OFS_CONTROL) begin
         control <= ((control & ~be_mask[11:0]) |
                     (writedata_in[11:0] & be_mask[11:0])) &
                    xcvr_ctrl_pkg::CONTROL_USED;
      end
   end

   // Flags latch on entry into a condition; a read clears only what it
   // returned, and a new event in that cycle survives the clear.
   always_comb begin
      flag_set = '0;
      flag_set[xcvr_ctrl_pkg::FL_RX_LOS +: L] =
         sync_b.rx_los & ~pins_prev.rx_los;
      flag_set[xcvr_ctrl_pkg::FL_TX_FAULT +: L] =
         sync_b.tx_fault & ~pins_prev.tx_fault;
      flag_set[xcvr_ctrl_pkg::FL_TX_LOS +: L] =
         sync_b.tx_los & ~pins_prev.tx_los;
      flag_set[xcvr_ctrl_pkg::FL_DATA_READY] =
         not_ready_prev & ~not_ready;
   end

   // Only the bits loaded into the read data are cleared; a flag that
   // latched during the wait state is kept for the next read.
   assign flag_clr = (take_rd && address_in == xcvr_ctrl_pkg::OFS_FLAGS) ?
                     readdata_out[12:0] : '0;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags <= xcvr_ctrl_pkg::FLAGS_RESET;
      end else if (pin_reset) begin
         flags <= xcvr_ctrl_pkg::FLAGS_RESET;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   assign pending = |(flags & ~mask);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         module_irq_n_out <= 1'b1;
      end else begin
         module_irq_n_out <= ~pending;
      end
   end

   // Squelch outputs follow synchronized inputs, lane off outputs the control word, one cycle later.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out <= 1'b0;
         low_power_out <= 1'b1;
         rx_squelch_out <= '0;
         tx_squelch_out <= '0;
         tx_off_out <= '1;
         rx_off_out <= '1;
      end else begin
         ready_out <= ~not_ready;
         low_power_out <= sync_b.low_power |
            control[xcvr_ctrl_pkg::CT_POWER_DOWN];
         rx_squelch_out <= sync_b.rx_los;
         tx_squelch_out <= sync_b.tx_los;
         tx_off_out <=
            control[xcvr_ctrl_pkg::CT_TX_DISABLE +: L];
         rx_off_out <= control[xcvr_ctrl_pkg::CT_RX_DISABLE +: L];
      end
   end

   // Checks kept beside the logic they guard.
   sequence s_read_flags;
      take_rd && address_in == xcvr_ctrl_pkg::OFS_FLAGS && flag_set == '0;
   endsequence

   sequence s_irq_release;
      ##1 (flags & $past(readdata_out[12:0])) == '0 ##1
         (module_irq_n_out || $past(flags & ~mask) != '0);
   endsequence

   property p_init_done;
      @(posedge clk_in) disable iff (!rst_n_in)
      (init_state == xcvr_ctrl_pkg::INIT_WAIT && !pin_reset &&
       init_cnt == 32'(INIT_CYCLES - 1)) |=> ##1 ready_out;
   endproperty
   a_init_done: assert property (p_init_done)
      else $error("init did not finish at its count");

   property p_lp_pin;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(sync_b.low_power) |=> low_power_out;
   endproperty
   a_lp_pin: assert property (p_lp_pin)
      else $error("low power pin not followed");

   property p_irq_low;
      @(posedge clk_in) disable iff (!rst_n_in)
      pending |=> !module_irq_n_out;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt not asserted");

   property p_read_clear;
      @(posedge clk_in) disable iff (!rst_n_in || pin_reset)
      s_read_flags |-> s_irq_release;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("flag read did not release interrupt");

   property p_rst_filter;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(pin_reset) |->
         $past(rst_low_cnt) == 9'(xcvr_ctrl_pkg::RST_MIN_CYCLES - 1);
   endproperty
   a_rst_filter: assert property (p_rst_filter)
      else $error("reset pin taken too early");

   property p_bus_answer;
      @(posedge clk_in) disable iff (!rst_n_in)
      ((read_in || write_in) && waitrequest_out) |=>
         ((read_in || write_in) |-> !waitrequest_out);
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus access not answered");

   property p_data_ready;
      @(posedge clk_in) disable iff (!rst_n_in || pin_reset)
      $fell(not_ready) |=> flags[xcvr_ctrl_pkg::FL_DATA_READY] ##0
         (mask[xcvr_ctrl_pkg::FL_DATA_READY] or ##1 !module_irq_n_out);
   endproperty
   a_data_ready: assert property (p_data_ready)
      else $error("data ready flag missing");

   property p_rx_los_flag;
      @(posedge clk_in) disable iff (!rst_n_in || pin_reset)
      $rose(sync_b.rx_los[0]) |=> flags[xcvr_ctrl_pkg::FL_RX_LOS];
   endproperty
   a_rx_los_flag: assert property (p_rx_los_flag)
      else $error("receive loss flag not set");

   property p_tx_fault_flag;
      @(posedge clk_in) disable iff (!rst_n_in || pin_reset)
      $rose(sync_b.tx_fault[0]) |=> flags[xcvr_ctrl_pkg::FL_TX_FAULT];
   endproperty
   a_tx_fault_flag: assert property (p_tx_fault_flag)
      else $error("transmit fault flag not set");

   property p_masked_quiet;
      @(posedge clk_in) disable iff (!rst_n_in)
      ((flags & ~mask) == '0) |=> module_irq_n_out;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("masked flag drives interrupt");

   property p_power_down;
      @(posedge clk_in) disable iff (!rst_n_in)
      control[xcvr_ctrl_pkg::CT_POWER_DOWN] |=> low_power_out;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("power down not entered");

   property p_rx_squelch;
      @(posedge clk_in) disable iff (!rst_n_in)
      $changed(sync_b.rx_los) |=> rx_squelch_out == $past(sync_b.rx_los);
   endproperty
   a_rx_squelch: assert property (p_rx_squelch)
      else $error("receive squelch not following");

   property p_tx_disable;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(control[xcvr_ctrl_pkg::CT_TX_DISABLE]) |=> tx_off_out[0];
   endproperty
   a_tx_disable: assert property (p_tx_disable)
      else $error("transmit lane not turned off");
endmodule : xcvr_ctrl

// ===== hdl/xcvr_ctrl_pkg.sv
// Purpose: Shared constants and types for the transceiver control block.
// Assumes: 100 MHz core clock, 32-bit Avalon-MM register window.
// Notes:   Register words are byte addressed and word aligned.
package xcvr_ctrl_pkg;
   localparam int          LANES           = 4;
   localparam int          ADDR_W          = 5;
   localparam int          CLK_HZ          = 100_000_000;
   // Initialization, reset-pin release and serial-ready bounds.
   localparam int          INIT_MS         = 2000;
   localparam int          INIT_CYCLES     = INIT_MS * (CLK_HZ / 1000);
   // Shortest low level on the reset pin that counts as a reset.
   localparam int          RST_MIN_US      = 2;
   localparam int          RST_MIN_CYCLES  = RST_MIN_US * (CLK_HZ / 1_000_000);
   localparam int          RST_CNT_W       = 9;
   localparam int          INIT_CNT_W      = 32;
   // Register byte offsets.
   localparam logic [4:0]  OFS_STATUS      = 5'h00;
   localparam logic [4:0]  OFS_FLAGS       = 5'h04;
   localparam logic [4:0]  OFS_MASK        = 5'h08;
   localparam logic [4:0]  OFS_CONTROL     = 5'h0c;
   // Status word fields.
   localparam int          ST_NOT_READY    = 16;
   localparam int          ST_READY        = 0;
   localparam int          ST_LOW_POWER    = 1;
   // Flag and mask word fields.
   localparam int          FL_RX_LOS       = 0;
   localparam int          FL_TX_FAULT     = 4;
   localparam int          FL_TX_LOS       = 8;
   localparam int          FL_DATA_READY   = 12;
   localparam int          FL_W            = 13;
   // Control word fields.
   localparam int          CT_POWER_DOWN   = 0;
   localparam int          CT_TX_DISABLE   = 4;
   localparam int          CT_RX_DISABLE   = 8;
   localparam int          CT_W            = 12;
   localparam logic [12:0] FLAGS_RESET     = 13'h0000;
   localparam logic [12:0] MASK_RESET      = 13'h0000;
   localparam logic [11:0] CONTROL_RESET   = 12'h000;
   localparam logic [11:0] CONTROL_USED    = 12'hff1;

   typedef struct packed {
      logic [LANES-1:0] rx_los;
      logic [LANES-1:0] tx_fault;
      logic [LANES-1:0] tx_los;
      logic             rst_n;
      logic             low_power;
   } pins_t;

   typedef enum logic [1:0] {
      INIT_WAIT,
      RUNNING,
      PIN_RESET
   } init_state_t;
endpackage : xcvr_ctrl_pkg

// ===== testbench/host_model.sv
// Purpose: Host board side: Avalon-MM master tasks and module pin drivers.
// Assumes: Caller runs tasks from one process; pins change after rising edges.
// Notes:   Bus answers are taken at the rising edge that sees waitrequest low.
module host_model (
   input  wire logic                          clk_in,
   input  wire logic                          waitrequest_in,
   input  wire logic [31:0]                   readdata_in,
   output logic      [4:0]                    address_out,
   output logic                               read_out,
   output logic                               write_out,
   output logic      [31:0]                   writedata_out,
   output logic      [3:0]                    byteenable_out,
   output xcvr_ctrl_pkg::pins_t               pins_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      address_out    = 5'h00;
      read_out       = 1'b0;
      write_out      = 1'b0;
      writedata_out  = 32'h0000_0000;
      byteenable_out = 4'hf;
      pins_out       = '{default: '0, rst_n: 1'b1};
   end
   // The request stays put until waitrequest is seen low at a rising edge.
   task automatic bus_cycle(input logic [4:0] a, input logic wr,
                            input logic [31:0] wd, input logic [3:0] be,
                            output logic [31:0] rd);
      int n;
      @(posedge clk_in);
      address_out    <= a;
      read_out       <= !wr;
      write_out      <= wr;
      writedata_out  <= wd;
      byteenable_out <= be;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_in);
         if (waitrequest_in === 1'b0) break;
      end
      if (n == 50) begin
         testbench.fail_count++;
         testbench.tally_and_finish();
      end
      rd = readdata_in;
      read_out  <= 1'b0;
      write_out <= 1'b0;
   endtask : bus_cycle
   task automatic set_lp(input logic v);
      @(posedge clk_in);
      pins_out.low_power <= v;
   endtask : set_lp
   // Level changes on the condition pins, one clean step each.
   task automatic set_cond(input logic [3:0] rx, input logic [3:0] txf,
                           input logic [3:0] txl);
      @(posedge clk_in);
      pins_out.rx_los   <= rx;
      pins_out.tx_fault <= txf;
      pins_out.tx_los   <= txl;
   endtask : set_cond
   // A real host keeps the reset pin low for at least the minimum time.
   task automatic reset_pulse(input int cycles);
      @(posedge clk_in);
      pins_out.rst_n <= 1'b0;
      repeat (cycles) @(posedge clk_in);
      pins_out.rst_n <= 1'b1;
   endtask : reset_pulse
endmodule : host_model

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the transceiver control block.
// Assumes: Initialization count shortened to 100 cycles.
// Notes:   Flag scenarios run from a table; reset pin cases follow by hand.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int INIT = 100;
   typedef struct packed {
      xcvr_ctrl_pkg::pins_t p;
      logic [12:0]          fl;
   } row_t;
   logic                 clk;
   logic                 rst_n;
   logic [4:0]           address;
   logic                 read;
   logic                 write;
   logic [31:0]          writedata;
   logic [3:0]           byteenable;
   logic [31:0]          readdata;
   logic                 waitrequest;
   xcvr_ctrl_pkg::pins_t pins;
   logic                 irq_n;
   logic                 ready;
   logic                 low_power;
   logic [3:0]           rx_sq;
   logic [3:0]           tx_sq;
   logic [3:0]           tx_off;
   logic [3:0]           rx_off;
   logic [31:0]          rd;
   int                   fail_count;
   int                   tests_run;
   int                   cnt;
   row_t                 rows [5];
   logic [31:0]          ctl [5];
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   host_model host (.clk_in(clk), .waitrequest_in(waitrequest),
      .readdata_in(readdata), .address_out(address), .read_out(read),
      .write_out(write), .writedata_out(writedata),
      .byteenable_out(byteenable), .pins_out(pins));
   xcvr_ctrl #(.INIT_CYCLES(INIT)) i_dut (.clk_in(clk), .rst_n_in(rst_n),
      .address_in(address), .read_in(read), .write_in(write),
      .writedata_in(writedata), .byteenable_in(byteenable),
      .readdata_out(readdata), .waitrequest_out(waitrequest),
      .module_rst_n_in(pins.rst_n), .low_power_pin_in(pins.low_power),
      .rx_los_in(pins.rx_los), .tx_fault_in(pins.tx_fault),
      .tx_los_in(pins.tx_los), .module_irq_n_out(irq_n),
      .ready_out(ready), .low_power_out(low_power),
      .rx_squelch_out(rx_sq), .tx_squelch_out(tx_sq),
      .tx_off_out(tx_off), .rx_off_out(rx_off));
   task automatic tally_and_finish();
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string name, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   task automatic rd_chk(input string name, input logic [4:0] a,
                         input logic [31:0] e);
      host.bus_cycle(a, 1'b0, 32'h0, 4'hf, rd);
      chk(name, e, rd);
   endtask : rd_chk
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      host.bus_cycle(a, 1'b1, d, be, rd);
   endtask : wr
   task automatic wait_irq(input logic e, input int bound);
      for (cnt = 0; cnt < bound && irq_n !== e; cnt++) @(negedge clk);
      chk("irq_n", e, irq_n);
      if (irq_n !== e) tally_and_finish();
   endtask : wait_irq
   // Counts cycles from now until ready, which must not come early.
   task automatic wait_ready();
      for (cnt = 0; cnt < INIT + 20 && ready !== 1'b1; cnt++) @(negedge clk);
      chk("ready_delay", 1'b1, cnt >= INIT && cnt <= INIT + 10);
      if (ready !== 1'b1) tally_and_finish();
   endtask : wait_ready
   initial begin
      fail_count = 0;
      tests_run  = 0;
      rst_n      = 1'b0;
      rows[0] = '{'{4'h1, 4'h0, 4'h0, 1'b1, 1'b0}, 13'h0001};
      rows[1] = '{'{4'h0, 4'h2, 4'h0, 1'b1, 1'b0}, 13'h0020};
      rows[2] = '{'{4'h0, 4'h0, 4'h4, 1'b1, 1'b0}, 13'h0400};
      rows[3] = '{'{4'h8, 4'h8, 4'h8, 1'b1, 1'b0}, 13'h0888};
      rows[4] = '{'{4'h6, 4'h5, 4'h3, 1'b1, 1'b0}, 13'h0356};
      ctl = '{32'hffff_ffff, 32'h0000_0001, 32'h0000_00a0,
              32'h0000_0500, 32'h0000_0000};
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("reset_outs", 3'b101, {irq_n, ready, low_power});
      @(posedge clk);
      rst_n <= 1'b1;
      wait_ready();
      wait_irq(1'b0, 10);
      rd_chk("status", 5'h00, 32'h0000_0001);
      rd_chk("flags_ready", 5'h04, 32'h0000_1000);
      wait_irq(1'b1, 10);
      rd_chk("flags_clr", 5'h04, 32'h0);
      foreach (rows[i]) begin
         host.set_cond(rows[i].p.rx_los, rows[i].p.tx_fault,
                       rows[i].p.tx_los);
         wait_irq(1'b0, 20);
         repeat (2) @(negedge clk);
         chk("rx_sq", rows[i].p.rx_los, rx_sq);
         chk("tx_sq", rows[i].p.tx_los, tx_sq);
         rd_chk("flags", 5'h04, {19'h0, rows[i].fl});
         wait_irq(1'b1, 10);
         host.set_cond(4'h0, 4'h0, 4'h0);
         repeat (6) @(negedge clk);
         chk("sq_off", 8'h00, {rx_sq, tx_sq});
         chk("irq_idle", 1'b1, irq_n);
      end
      // A masked flag still latches, so clearing the mask must raise irq.
      wr(5'h08, 32'h0000_0001, 4'hf);
      host.set_cond(4'h1, 4'h0, 4'h0);
      repeat (20) @(negedge clk);
      chk("irq_masked", 1'b1, irq_n);
      wr(5'h08, 32'h0, 4'hf);
      wait_irq(1'b0, 20);
      rd_chk("flags_m", 5'h04, 32'h0000_0001);
      wait_irq(1'b1, 10);
      host.set_cond(4'h0, 4'h0, 4'h0);
      foreach (ctl[i]) begin
         wr(5'h0c, ctl[i], 4'hf);
         repeat (5) @(negedge clk);
         chk("power", ctl[i][0], low_power);
         chk("tx_off", ctl[i][7:4], tx_off);
         chk("rx_off", ctl[i][11:8], rx_off);
         rd_chk("control", 5'h0c, ctl[i] & 32'h0000_0ff1);
      end
      host.set_lp(1'b1);
      repeat (5) @(negedge clk);
      chk("lp_pin", 1'b1, low_power);
      rd_chk("status_lp", 5'h00, 32'h0000_0003);
      host.set_lp(1'b0);
      wr(5'h08, 32'h0000_1fff, 4'h1);
      rd_chk("mask_be", 5'h08, 32'h0000_00ff);
      wr(5'h10, 32'hffff_ffff, 4'hf);
      rd_chk("unmapped", 5'h10, 32'h0);
      rd_chk("unmapped2", 5'h14, 32'h0);
      host.reset_pulse(150);
      repeat (10) @(negedge clk);
      chk("short_pulse", 1'b1, ready);
      rd_chk("mask_kept", 5'h08, 32'h0000_00ff);
      host.reset_pulse(250);
      @(negedge clk);
      chk("long_pulse", 1'b0, ready);
      wait_ready();
      rd_chk("mask_clr", 5'h08, 32'h0);
      tally_and_finish();
   end
endmodule : testbench
